// ---- rtl/evt_fault_supervisor.sv ----
// event mask and internal fault supervisor top
// assumes synchronous inputs, plain register port, one 100 MHz clock
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns

// Overview of operation
// - digital input changes become events 11..20; all disabled at reset
// - two temperature stages' alarm and trip edges become events 21..28, disabled
// - first stage alarm activation is event 21 weight 1, reset event 22
// - a fault first triggers restarts before being declared permanent
// - permanent fault flashes ready and drives supervision contact
// - during permanent fault other contacts forced idle and locked
// - a numeric fault code is shown when permanent fault declared
// - fault indication has top display priority
// - clear requests ignored while ready flashes
// - fault gone: stop flashing, keep indication until clear or start-up
// - contact faults coded 4 through 8
// - enable fault coded 9; combined faults 10, 11, 12
// - memory faults coded 30, 50, 59, 51-54, 56, 55
// - module faults coded 75, 80, 81, 82, 85, 86, 90, 95
// - reference voltage codes 131..223 set, measuring unit 253
// - settings read zero while parameter memory fault present
module evt_fault_supervisor (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_irq,
  input  wire logic [4:0]  i_contact_cmd,
  input  wire logic [4:0]  i_digital_input,
  input  wire logic [3:0]  i_temp_stage,
  input  wire logic        i_fault_detect,
  input  wire logic [7:0]  i_fault_code,
  input  wire logic        i_motor_start,
  input  wire logic [15:0] i_setting,
  output logic      [4:0]  o_contact,
  output logic             o_internal_fault,
  output logic             o_ready_led,
  output logic             o_restart,
  output logic             o_fault_shown,
  output logic      [7:0]  o_fault_code,
  output logic             o_event_valid,
  output logic      [4:0]  o_event_index,
  output logic      [15:0] o_setting
);
  import evt_sup_pkg::*;

  // ==========================================================
  // registers and state
  logic [9:0]     output_contact_event_mask;
  logic [9:0]     digital_input_event_mask;
  logic [7:0]     temperature_stage_event_mask;
  logic [2:0]     evt_status;
  logic [2:0]     irq_mask;
  logic [4:0]     last_event;
  sup_state_type  state;
  logic [31:0]    cnt;
  logic [1:0]     tries;
  logic [31:0]    flash_cnt;
  logic           flash;
  logic [7:0]     shown_code;
  logic           shown;
  logic           led_phase;

  evt_if #(.N(5)) out_evt ();
  evt_if #(.N(5)) di_evt ();
  evt_if #(.N(4)) tmp_evt ();

  assign out_evt.mask = output_contact_event_mask;
  assign di_evt.mask  = digital_input_event_mask;
  assign tmp_evt.mask = temperature_stage_event_mask;

  // ==========================================================
  // event generators
  edge_event_gen #(.N(5), .BASE(EVT_BASE_OUT)) u_out (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_level   (o_contact),
    .evt       (out_evt.detector)
  );
  edge_event_gen #(.N(5), .BASE(EVT_BASE_DI)) u_di (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_level   (i_digital_input),
    .evt       (di_evt.detector)
  );
  // stage bits: alarm1, trip1, alarm2, trip2 -> events 21..28
  edge_event_gen #(.N(4), .BASE(EVT_BASE_TEMP)) u_tmp (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_level   (i_temp_stage),
    .evt       (tmp_evt.detector)
  );

  // groups can fire together; fixed priority, contacts first.
  // limitation: a lower group's event in the same cycle is dropped
  wire        any_evt   = out_evt.valid | di_evt.valid | tmp_evt.valid;
  wire [4:0]  sel_index = out_evt.valid ? out_evt.index :
                          di_evt.valid  ? di_evt.index  : tmp_evt.index;

  // ==========================================================
  // fault code classification
  function automatic logic code_known(input logic [7:0] c);
    logic r;
    r = 1'b0;
    if (c >= FC_CONTACT_BASE && c <= FC_FEEDBACK_C) r = 1'b1;
    if (c == FC_SUPPLY_A || c == FC_SUPPLY_B) r = 1'b1;
    if (c == FC_PROTO_CONFIG) r = 1'b1;
    if (c == FC_PROG_MEM || c == FC_WORK_A || c == FC_WORK_B) r = 1'b1;
    if (c >= FC_PAR_A && c <= FC_PAR_E) r = 1'b1;
    if (c == FC_TMOD_FAULTY || (c >= FC_TMOD_MISSING && c <= FC_TMOD_CONFIG)) r = 1'b1;
    if (c == FC_PSU_FAULTY || c == FC_PSU_UNKNOWN) r = 1'b1;
    if (c == FC_HW_CONFIG || c == FC_COMM_UNKNOWN) r = 1'b1;
    if (c == FC_REF_A || c == FC_REF_B || c == FC_REF_C) r = 1'b1;
    if (c == FC_REF_D || c == FC_REF_E || c == FC_REF_F) r = 1'b1;
    if (c == FC_MEAS) r = 1'b1;
    return r;
  endfunction

  // unlisted codes are still faults; they pass through unchanged
  wire       code_listed = code_known(i_fault_code);
  wire       par_mem_fault = i_fault_detect &&
                             ((i_fault_code >= FC_PAR_A && i_fault_code <= FC_PAR_D) ||
                              i_fault_code == FC_PAR_E);

  // ==========================================================
  // register decode
  wire wr_out   = i_wr && (i_addr == OFF_OUT_MASK);
  wire wr_di    = i_wr && (i_addr == OFF_DI_MASK);
  wire wr_tmp   = i_wr && (i_addr == OFF_TEMP_MASK);
  wire wr_irqm  = i_wr && (i_addr == OFF_IRQ_MASK);
  wire wr_ctl   = i_wr && (i_addr == OFF_CONTROL);
  wire rd_stat  = i_rd && (i_addr == OFF_EVT_STATUS);
  wire clr_req  = wr_ctl && i_wdata[CTL_CLEAR];
  wire sw_start = wr_ctl && i_wdata[CTL_START];
  wire start_up = i_motor_start | sw_start;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_addr == OFF_OUT_MASK) begin
      rd_mux = {22'h00_0000, output_contact_event_mask};
    end else if (i_addr == OFF_DI_MASK) begin
      rd_mux = {22'h00_0000, digital_input_event_mask};
    end else if (i_addr == OFF_TEMP_MASK) begin
      rd_mux = {24'h00_0000, temperature_stage_event_mask};
    end else if (i_addr == OFF_EVT_STATUS) begin
      rd_mux = {29'h0000_0000, evt_status};
    end else if (i_addr == OFF_IRQ_MASK) begin
      rd_mux = {29'h0000_0000, irq_mask};
    end else if (i_addr == OFF_FAULT) begin
      rd_mux = {21'h00_0000, code_listed, flash, shown, shown_code};
    end else if (i_addr == OFF_SETTING) begin
      rd_mux = {16'h0000, (par_mem_fault ? 16'h0000 : i_setting)};
    end else if (i_addr == OFF_LAST_EVENT) begin
      rd_mux = {27'h000_0000, last_event};
    end
  end

  // ==========================================================
  // supervision state machine
  wire restart_done = (cnt == 32'(RESTART_CYC - 1));
  sup_state_type next_state;
  always_comb begin
    next_state = state;
    case (state)
      SUP_OK: begin
        if (i_fault_detect) next_state = SUP_RESTART;
      end
      SUP_RESTART: begin
        if (restart_done) begin
          if (!i_fault_detect) next_state = SUP_OK;
          else if (tries == RESTART_TRIES) next_state = SUP_PERMANENT;
        end
      end
      SUP_PERMANENT: begin
        if (!i_fault_detect) next_state = SUP_OK;
      end
      default: next_state = SUP_OK;
    endcase
  end

  wire entering_perm = (state != SUP_PERMANENT) && (next_state == SUP_PERMANENT);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= SUP_OK;
      cnt   <= 32'h0000_0000;
      tries <= 2'h0;
    end else begin
      state <= next_state;
      if (state != SUP_RESTART || restart_done) cnt <= 32'h0000_0000;
      else cnt <= cnt + 32'h0000_0001;
      if (state == SUP_OK) tries <= 2'h0;
      else if (state == SUP_RESTART && restart_done) tries <= tries + 2'h1;
    end
  end

  // ready flash divider
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flash_cnt <= 32'h0000_0000;
      flash     <= 1'b0;
    end else if (state == SUP_PERMANENT) begin
      flash <= 1'b1;
      if (flash_cnt == 32'(FLASH_HALF_CYC - 1)) flash_cnt <= 32'h0000_0000;
      else flash_cnt <= flash_cnt + 32'h0000_0001;
    end else begin
      flash     <= 1'b0;
      flash_cnt <= 32'h0000_0000;
    end
  end

  // fault indication: highest priority, latched code
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shown      <= 1'b0;
      shown_code <= FC_NONE;
    end else if (entering_perm) begin
      shown      <= 1'b1;
      shown_code <= i_fault_code;
    end else if (!flash && state != SUP_PERMANENT && (clr_req || start_up)) begin
      shown      <= 1'b0;
      shown_code <= FC_NONE;
    end
  end

  // ==========================================================
  // registers, interrupts and outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      output_contact_event_mask    <= OUT_MASK_RST;
      digital_input_event_mask     <= DI_MASK_RST;
      temperature_stage_event_mask <= TEMP_MASK_RST;
      irq_mask                     <= IRQ_MASK_RST;
      evt_status                   <= 3'h0;
      last_event                   <= 5'h00;
    end else begin
      if (wr_out) output_contact_event_mask <= i_wdata[9:0];
      if (wr_di) digital_input_event_mask <= i_wdata[9:0];
      if (wr_tmp) temperature_stage_event_mask <= i_wdata[7:0];
      if (wr_irqm) irq_mask <= i_wdata[2:0];
      if (any_evt) last_event <= sel_index;
      // set wins over the read-clear
      evt_status <= (rd_stat ? 3'h0 : evt_status) |
                    {(state == SUP_OK && next_state == SUP_RESTART),
                     entering_perm, any_evt};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata          <= 32'h0000_0000;
      o_irq            <= 1'b0;
      o_contact        <= 5'h00;
      o_internal_fault <= 1'b0;
      o_ready_led      <= 1'b0;
      o_restart        <= 1'b0;
      o_fault_shown    <= 1'b0;
      o_fault_code     <= FC_NONE;
      o_event_valid    <= 1'b0;
      o_event_index    <= 5'h00;
      o_setting        <= 16'h0000;
    end else begin
      o_rdata          <= i_rd ? rd_mux : 32'h0000_0000;
      o_irq            <= |(evt_status & irq_mask);
      o_contact        <= (state == SUP_PERMANENT) ? 5'h00 : i_contact_cmd;
      o_internal_fault <= (state == SUP_PERMANENT);
      o_ready_led      <= (state == SUP_PERMANENT) ? led_phase : 1'b1;
      o_restart        <= (state == SUP_RESTART);
      o_fault_shown    <= shown;
      o_fault_code     <= shown_code;
      o_event_valid    <= any_evt;
      o_event_index    <= sel_index;
      o_setting        <= par_mem_fault ? 16'h0000 : i_setting;
    end
  end

  // led phase toggles each half period
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) led_phase <= 1'b1;
    else if (state != SUP_PERMANENT) led_phase <= 1'b1;
    else if (flash_cnt == 32'(FLASH_HALF_CYC - 1)) led_phase <= ~led_phase;
  end
endmodule

// ---- shared/evt_sup_pkg.sv ----
// package for the event mask and internal fault supervisor
// assumes a single 100 MHz clock domain
package evt_sup_pkg;
  // ==========================================================
  // register map (word offsets on the plain register port)
  localparam logic [3:0] OFF_OUT_MASK    = 4'h0;
  localparam logic [3:0] OFF_DI_MASK     = 4'h1;
  localparam logic [3:0] OFF_TEMP_MASK   = 4'h2;
  localparam logic [3:0] OFF_EVT_STATUS  = 4'h3;
  localparam logic [3:0] OFF_IRQ_MASK    = 4'h4;
  localparam logic [3:0] OFF_FAULT       = 4'h5;
  localparam logic [3:0] OFF_CONTROL     = 4'h6;
  localparam logic [3:0] OFF_SETTING     = 4'h7;
  localparam logic [3:0] OFF_LAST_EVENT  = 4'h8;

  // ==========================================================
  // reset values
  localparam logic [9:0]  OUT_MASK_RST   = 10'h003;
  localparam logic [9:0]  DI_MASK_RST    = 10'h000;
  localparam logic [7:0]  TEMP_MASK_RST  = 8'h00;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

  // ==========================================================
  // event numbering bases
  localparam logic [4:0]  EVT_BASE_OUT   = 5'h01;
  localparam logic [4:0]  EVT_BASE_DI    = 5'h0B;
  localparam logic [4:0]  EVT_BASE_TEMP  = 5'h15;

  // ==========================================================
  // status / control bit positions
  localparam int ST_EVENT   = 0;
  localparam int ST_FAULT   = 1;
  localparam int ST_RECOVER = 2;
  localparam int CTL_CLEAR  = 0;
  localparam int CTL_START  = 1;

  // ==========================================================
  // timing
  localparam int CLK_MHZ        = 100;
  localparam int FLASH_HALF_MS  = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;
  localparam int RESTART_US     = 100;
  localparam int RESTART_CYC    = RESTART_US * CLK_MHZ;
  localparam logic [1:0] RESTART_TRIES = 2'h2;

  // ==========================================================
  // fault codes
  localparam logic [7:0] FC_NONE = 8'h00;
  localparam logic [7:0] FC_CONTACT_BASE = 8'h04;
  localparam logic [7:0] FC_ENABLE = 8'h09;
  localparam logic [7:0] FC_FEEDBACK_A = 8'h0A;
  localparam logic [7:0] FC_FEEDBACK_B = 8'h0B;
  localparam logic [7:0] FC_FEEDBACK_C = 8'h0C;
  localparam logic [7:0] FC_SUPPLY_A = 8'h14;
  localparam logic [7:0] FC_SUPPLY_B = 8'h15;
  localparam logic [7:0] FC_PROG_MEM = 8'h1E;
  localparam logic [7:0] FC_WORK_A = 8'h32;
  localparam logic [7:0] FC_WORK_B = 8'h3B;
  localparam logic [7:0] FC_PAR_A = 8'h33;
  localparam logic [7:0] FC_PAR_B = 8'h34;
  localparam logic [7:0] FC_PAR_C = 8'h35;
  localparam logic [7:0] FC_PAR_D = 8'h36;
  localparam logic [7:0] FC_CAL_MEM = 8'h37;
  localparam logic [7:0] FC_PAR_E = 8'h38;
  localparam logic [7:0] FC_TMOD_FAULTY = 8'h4B;
  localparam logic [7:0] FC_TMOD_MISSING = 8'h50;
  localparam logic [7:0] FC_TMOD_UNKNOWN = 8'h51;
  localparam logic [7:0] FC_TMOD_CONFIG = 8'h52;
  localparam logic [7:0] FC_PSU_FAULTY = 8'h55;
  localparam logic [7:0] FC_PSU_UNKNOWN = 8'h56;
  localparam logic [7:0] FC_HW_CONFIG = 8'h5A;
  localparam logic [7:0] FC_COMM_UNKNOWN = 8'h5F;
  localparam logic [7:0] FC_PROTO_CONFIG = 8'h68;
  localparam logic [7:0] FC_REF_A = 8'h83;
  localparam logic [7:0] FC_REF_B = 8'h8B;
  localparam logic [7:0] FC_REF_C = 8'hC3;
  localparam logic [7:0] FC_REF_D = 8'hCB;
  localparam logic [7:0] FC_REF_E = 8'hDE;
  localparam logic [7:0] FC_REF_F = 8'hDF;
  localparam logic [7:0] FC_MEAS = 8'hFD;

  typedef enum logic [1:0] {
    SUP_OK,
    SUP_RESTART,
    SUP_PERMANENT
  } sup_state_type;
endpackage

// ---- shared/evt_if.sv ----
// interface carrying one masked event group from detector to top
// assumes both ends on i_sys_clk
`timescale 1ns/1ns
interface evt_if #(parameter int N = 5);
  logic [2*N-1:0] mask;
  logic           valid;
  logic [4:0]     index;
  modport detector (input mask, output valid, output index);
  modport consumer (output mask, input valid, input index);
endinterface

// ---- rtl/edge_event_gen.sv ----
// edge detector for a group of levels, producing masked numbered events
// assumes levels synchronous to i_sys_clk
`timescale 1ns/1ns
module edge_event_gen #(
  parameter int         N    = 5,
  parameter logic [4:0] BASE = 5'h01
) (
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst_b,
  input  wire logic [N-1:0] i_level,
  evt_if.detector     evt
);
  logic [N-1:0]   prev;
  logic [2*N-1:0] hits;
  logic [2*N-1:0] pend;
  logic [2*N-1:0] next_pend;
  logic [2*N-1:0] pick;
  logic [4:0]     pick_idx;

  // ==========================================================
  // activation at bit 2k, reset at bit 2k+1
  genvar k;
  generate
    for (k = 0; k < N; k++) begin : g_edge
      assign hits[2*k]   = i_level[k] & ~prev[k];
      assign hits[2*k+1] = ~i_level[k] & prev[k];
    end
  endgenerate

  // one event per cycle; simultaneous ones wait in pend, lowest first
  assign pick = (pend | (hits & evt.mask)) & ~((pend | (hits & evt.mask)) - 1'b1);
  always_comb begin
    pick_idx = 5'h00;
    for (int i = 2*N-1; i >= 0; i--) begin
      if (pick[i]) begin
        pick_idx = 5'(i);
      end
    end
  end
  assign next_pend = (pend | (hits & evt.mask)) & ~pick;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev      <= '0;
      pend      <= '0;
      evt.valid <= 1'b0;
      evt.index <= 5'h00;
    end else begin
      prev      <= i_level;
      pend      <= next_pend;
      evt.valid <= |pick;
      evt.index <= BASE + pick_idx;
    end
  end
endmodule

// ---- tb/fault_source.sv ----
// fault source model standing in for the self-test logic of the device
// assumes inputs change just after a rising edge of i_sys_clk
`timescale 1ns/1ns
module fault_source (
  input  wire logic       i_sys_clk,
  input  wire logic       i_inject,
  input  wire logic [7:0] i_code,
  output logic            o_fault_detect,
  output logic [7:0]      o_fault_code
);
  // ==========================================================
  // fault level and code
  initial begin
    o_fault_detect = 1'b0;
    o_fault_code   = 8'h00;
  end
  // with no fault the code is not meaningful: show a changing value
  always @(posedge i_sys_clk) begin
    o_fault_detect <= i_inject;
    o_fault_code   <= i_inject ? i_code : ~o_fault_code;
  end
endmodule

// ---- tb/evt_sup_checker.sv ----
// concurrent checks on the ports of the supervisor top
// assumes one clock domain and the asynchronous low reset
`timescale 1ns/1ns
module evt_sup_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        o_irq,
  input wire logic [4:0]  i_contact_cmd,
  input wire logic        i_fault_detect,
  input wire logic [7:0]  i_fault_code,
  input wire logic [4:0]  o_contact,
  input wire logic        o_internal_fault,
  input wire logic        o_ready_led,
  input wire logic        o_restart,
  input wire logic        o_fault_shown,
  input wire logic [7:0]  o_fault_code,
  input wire logic        o_event_valid,
  input wire logic [4:0]  o_event_index,
  input wire logic [15:0] o_setting
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================================
  // properties
  property p_lock;
    o_internal_fault |-> o_contact == 5'h00;
  endproperty
  property p_follow;
    !o_internal_fault && !$past(o_internal_fault) |-> o_contact == $past(i_contact_cmd);
  endproperty
  property p_ready;
    $past(i_rst_b) && !o_internal_fault && !$past(o_internal_fault) |-> o_ready_led;
  endproperty
  property p_restart_first;
    $rose(o_internal_fault) |-> $past(o_restart);
  endproperty
  property p_shown;
    o_internal_fault && $past(o_internal_fault) |-> o_fault_shown;
  endproperty
  property p_code_hold;
    o_internal_fault && $past(o_internal_fault) && $past(o_fault_shown)
      |-> $stable(o_fault_code);
  endproperty
  property p_no_clear;
    o_internal_fault && o_fault_shown |=> o_fault_shown;
  endproperty
  // parameter memory codes 51..54 and 56
  property p_zero;
    i_fault_detect && (i_fault_code inside {[8'h33:8'h36], 8'h38})
      |=> o_setting == 16'h0000;
  endproperty
  property p_evt_range;
    o_event_valid |-> o_event_index inside {[5'h01:5'h1C]};
  endproperty
  // ==========================================================
  // assertions
  a_lock: assert property (p_lock) else $error("contact driven in fault");
  a_follow: assert property (p_follow) else $error("contact not following");
  a_ready: assert property (p_ready) else $error("ready off in service");
  a_restart_first: assert property (p_restart_first) else $error("no restart");
  a_shown: assert property (p_shown) else $error("fault not shown");
  a_code_hold: assert property (p_code_hold) else $error("code replaced");
  a_no_clear: assert property (p_no_clear) else $error("cleared while flashing");
  a_zero: assert property (p_zero) else $error("setting not zero");
  a_evt_range: assert property (p_evt_range) else $error("bad event index");
  c_event: cover property (o_event_valid);
  c_fault: cover property ($rose(o_internal_fault));
  c_irq: cover property ($rose(o_irq));
endmodule
bind evt_fault_supervisor evt_sup_checker u_chk (
  .i_sys_clk, .i_rst_b, .o_irq, .i_contact_cmd, .i_fault_detect, .i_fault_code,
  .o_contact, .o_internal_fault,
  .o_ready_led, .o_restart, .o_fault_shown, .o_fault_code, .o_event_valid,
  .o_event_index, .o_setting
);

// ---- tb/tb_evt_fault_supervisor.sv ----
// self-checking bench for the event mask and fault supervisor
// assumes the package offsets and the hand-over timing
`timescale 1ns/1ns
module tb_evt_fault_supervisor;
  import evt_sup_pkg::*;
  logic        clk, rst_b, wr, rd, irq, inject, mstart, ifault, led, rstr, shown, evv;
  logic [3:0]  addr, temp;
  logic [31:0] wdata, rdata, d;
  logic [4:0]  cmd, din, contact, evi;
  logic [7:0]  icode, fcode, ocode;
  logic [15:0] setting, osetting;
  logic        fdet;
  int          n_errors, compares, i;
  evt_fault_supervisor uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
    .i_contact_cmd(cmd), .i_digital_input(din), .i_temp_stage(temp),
    .i_fault_detect(fdet), .i_fault_code(fcode), .i_motor_start(mstart),
    .i_setting(setting), .o_contact(contact), .o_internal_fault(ifault),
    .o_ready_led(led), .o_restart(rstr), .o_fault_shown(shown),
    .o_fault_code(ocode), .o_event_valid(evv), .o_event_index(evi), .o_setting(osetting));
  fault_source u_src (.i_sys_clk(clk), .i_inject(inject), .i_code(icode),
    .o_fault_detect(fdet), .o_fault_code(fcode));
  // ==========================================================
  // common tasks
  task test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata;
  endtask
  // first event within six cycles; returns at once so a queued one stays visible
  task expect_evt(input logic [4:0] idx, input logic want);
    logic seen;
    logic [4:0] got;
    int k;
    seen = 1'b0; got = 5'h00;
    for (k = 0; k < 6 && !seen; k++) begin
      @(posedge clk); #1;
      if (evv === 1'b1) begin seen = 1'b1; got = evi; end
    end
    check({31'h0, seen}, {31'h0, want});
    if (want) check({27'h0, got}, {27'h0, idx});
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && s !== v; k++) @(posedge clk);
    #1 if (s !== v) begin n_errors++; $display("[FAIL] %0t wait ran out", $time); test_done; end
  endtask
  // ==========================================================
  // scenarios
  task t_reset_values;
    reg_rd(OFF_OUT_MASK, d); check(d, 32'h0000_0003);
    reg_rd(OFF_DI_MASK, d); check(d, 32'h0000_0000);
    reg_rd(OFF_TEMP_MASK, d); check(d, 32'h0000_0000);
    reg_rd(4'hF, d); check(d, 32'h0000_0000);
  endtask
  task t_contacts;
    @(posedge clk); cmd <= 5'h01; expect_evt(5'h01, 1'b1);
    @(posedge clk); cmd <= 5'h00; expect_evt(5'h02, 1'b1);
    @(posedge clk); cmd <= 5'h02; expect_evt(5'h00, 1'b0);
    reg_wr(OFF_OUT_MASK, 32'h0000_03FF);
    @(posedge clk); cmd <= 5'h12; expect_evt(5'h09, 1'b1);
    @(posedge clk); cmd <= 5'h00; expect_evt(5'h04, 1'b1);
    expect_evt(5'h0A, 1'b1);
  endtask
  task t_inputs;
    @(posedge clk); din <= 5'h01; expect_evt(5'h00, 1'b0);
    reg_wr(OFF_DI_MASK, 32'h0000_03FF);
    @(posedge clk); din <= 5'h11; expect_evt(5'h13, 1'b1);
    @(posedge clk); din <= 5'h01; expect_evt(5'h14, 1'b1);
  endtask
  task t_temperature;
    reg_wr(OFF_TEMP_MASK, 32'h0000_0001);
    @(posedge clk); temp <= 4'h1; expect_evt(5'h15, 1'b1);
    @(posedge clk); temp <= 4'h0; expect_evt(5'h00, 1'b0);
    reg_wr(OFF_TEMP_MASK, 32'h0000_00FF);
    @(posedge clk); temp <= 4'h8; expect_evt(5'h1B, 1'b1);
    @(posedge clk); temp <= 4'h0; expect_evt(5'h1C, 1'b1);
  endtask
  task t_interrupt;
    reg_rd(OFF_EVT_STATUS, d);
    reg_wr(OFF_IRQ_MASK, 32'h0000_0001);
    @(posedge clk); din <= 5'h00; expect_evt(5'h0C, 1'b1);
    @(posedge clk);
    #1 check({31'h0, irq}, 32'h1);
    reg_rd(OFF_EVT_STATUS, d); check(d & 32'h1, 32'h1);
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
  endtask
  task t_fault;
    @(posedge clk); cmd <= 5'h1F; icode <= FC_PAR_A; inject <= 1'b1;
    wait_for(rstr, 1'b1, 20);
    check({31'h0, ifault}, 32'h0);
    wait_for(ifault, 1'b1, 40000);
    check({27'h0, contact}, 32'h0);
    check({31'h0, shown}, 32'h1);
    check({24'h0, ocode}, 32'h0000_0033);
    check({16'h0, osetting}, 32'h0);
    reg_wr(OFF_CONTROL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    reg_rd(OFF_FAULT, d); check(d, 32'h0000_0733);
    @(posedge clk); inject <= 1'b0;
    wait_for(ifault, 1'b0, 10);
    repeat (3) @(posedge clk);
    #1 check({31'h0, led}, 32'h1);
    check({31'h0, shown}, 32'h1);
    check({27'h0, contact}, 32'h0000_001F);
    @(posedge clk); mstart <= 1'b1;
    @(posedge clk); mstart <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check({31'h0, shown}, 32'h0);
  endtask
  // ==========================================================
  // clock, reset and sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    n_errors = 0; compares = 0;
    rst_b = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 32'h0000_0000;
    cmd = 5'h00; din = 5'h00; temp = 4'h0; mstart = 1'b0; setting = 16'h5A5A;
    inject = 1'b0; icode = 8'h00;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset_values;
    t_contacts;
    t_inputs;
    t_temperature;
    t_interrupt;
    t_fault;
    test_done;
  end
endmodule
